// *** core/adcc_ctrl.sv ***
`include "adcc_map.svh"
`default_nettype none
// Function
// R1: channel 15 carries the on-chip temperature sensor voltage
// R2: six event flags, each with its own interrupt enable
// R3: window flag sets on result outside thresholds; write one clears
// R4: empty status is high exactly when the result fifo is empty
// R5: full status is high exactly when the result fifo is full
// R6: overrun flag sets when a conversion ends with fifo full; w1c
// R7: sequence-done flag sets after the last conversion; w1c
// R8: conversion-done flag sets once result is stored; w1c or fifo read
// R9: sample-end flag sets when the sampling phase ends
// R10: ready flag sets after enable when converter accepts requests; w1c
// R11: stop aborts conversion, reads one meanwhile, hardware clears it
// R12: software sets stop only while start is one and disable zero
// R13: start converts at once on software trigger, else on hardware trigger
// R14: start clears at sequence end, conversion end in disc mode, or stop; code: those two only on software trigger, sequence end not in cont mode
// R15: software sets start only while enable is one and disable zero
// R16: disable powers down; hardware then clears disable and enable
// R17: software sets disable only while enable is one and start zero
// R18: enable starts power-up; enable reads zero while converter is off
// R19: software sets enable only when all four command bits are zero
// R20: differential select one samples differentially, zero single-ended
// R21: all registers open to any privilege; reserved bits read zero
// R22: overwrite mode replaces stored data with the newest result
// R23: no dma requests after overrun until the flag is cleared
// R24: wait mode starts a conversion only while fifo is not full
// R25: interrupt when any enabled flag is set; writing zero keeps flags
module adcc_ctrl #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic reg_sel,
    input wire logic reg_wr,
    input wire logic [6:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    input wire logic core_ready_pulse,
    input wire logic core_off_pulse,
    input wire logic core_stop_done,
    input wire logic core_sample_end,
    input wire logic core_conv_done,
    input wire logic core_seq_last,
    input wire adcc_pkg::adcc_sample_t core_data,
    input wire logic [3:0] core_channel,
    input wire logic hw_trigger,
    input wire logic dma_ack,
    output logic core_power_on,
    output logic core_start_conv,
    output logic core_abort,
    output logic core_differential_select_sel,
    output logic core_temp_sel,
    output logic dma_req,
    output logic irq
);
    import adcc_pkg::*;

    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("fifo depth below 2");
    end

    function automatic logic w1c(input logic cur, input logic set, input logic clr);
        return set | (cur & ~clr);
    endfunction

    // ----------------------------------------------------------------
    // register access decode
    // ----------------------------------------------------------------
    wire acc_wr = reg_sel & reg_wr;
    wire acc_rd = reg_sel & ~reg_wr;
    wire wr_status = acc_wr & (reg_addr == `ADCC_OFF_STATUS);
    wire wr_irq_en = acc_wr & (reg_addr == `ADCC_OFF_IRQ_EN);
    wire wr_cmd = acc_wr & (reg_addr == `ADCC_OFF_CMD);
    wire fifo_rd = acc_rd & (reg_addr == `ADCC_OFF_FIFO);

    adcc_state_t state;
    adcc_state_t next_state;
    logic [`ADCC_NUM_EV-1:0] ev;
    logic [`ADCC_NUM_EV-1:0] next_ev;
    logic [`ADCC_NUM_EV-1:0] ev_set;
    logic [`ADCC_NUM_EV-1:0] ev_clr;
    logic [`ADCC_NUM_EV-1:0] ier;
    logic [31:0] cfg1;
    logic [31:0] cfg2;
    logic [31:0] smp;
    logic [31:0] wdg;
    logic [31:0] thr;
    logic [31:0] seq_lo;
    logic [31:0] seq_hi;
    logic cmd_en;
    logic cmd_dis;
    logic cmd_start;
    logic cmd_stop;

    adcc_fifo_if #(.W(12)) fif();
    adcc_fifo #(.W(12), .D(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .fif(fif)
    );

    // ----------------------------------------------------------------
    // configuration fields
    // ----------------------------------------------------------------
    wire dma_en = cfg1[`ADCC_CFG_DMA];
    wire [2:0] trig_mode = cfg1[`ADCC_CFG_TRIG_HI:`ADCC_CFG_TRIG_LO];
    wire trig_sw = (trig_mode == `ADCC_TRIG_SW);
    wire ovw_mode = cfg1[`ADCC_CFG_OVW];
    wire wait_mode = cfg1[`ADCC_CFG_WAIT];
    wire cont_mode = cfg1[`ADCC_CFG_CONT];
    wire disc_mode = cfg1[`ADCC_CFG_DISC];
    wire awd_en = wdg[`ADCC_WDG_EN];
    wire awd_sgl = wdg[`ADCC_WDG_SGL];
    wire [3:0] awd_ch = wdg[`ADCC_WDG_CH_HI:`ADCC_WDG_CH_LO];
    wire [11:0] thr_lo = thr[`ADCC_THR_LT_HI:`ADCC_THR_LT_LO];
    wire [11:0] thr_hi = thr[`ADCC_THR_HT_HI:`ADCC_THR_HT_LO];
    // configuration is frozen while a start is pending or running
    wire cfg_wr = acc_wr & ~cmd_start;

    // ----------------------------------------------------------------
    // conversion events
    // ----------------------------------------------------------------
    wire busy = (state == adcc_busy);
    wire conv_end = core_conv_done & busy;
    wire conv_stored = conv_end & (~fif.full | ovw_mode); // [R22]
    wire seq_end = conv_end & core_seq_last;
    wire awd_watch = awd_en & (~awd_sgl | (core_channel == awd_ch));
    wire awd_hit = awd_watch & ((core_data < thr_lo) | (core_data > thr_hi)); // [R3]
    wire wait_block = wait_mode & fif.full; // [R24]
    wire trig_ok = trig_sw | hw_trigger; // [R13]
    wire start_go = (state == adcc_idle) & cmd_start & ~cmd_stop & ~cmd_dis & trig_ok
        & ~wait_block; // [R13] [R24]

    // ----------------------------------------------------------------
    // command handshake
    // ----------------------------------------------------------------
    wire cmd_idle = ~cmd_en & ~cmd_dis & ~cmd_start & ~cmd_stop;
    wire en_set = wr_cmd & reg_wdata[`ADCC_CMD_EN] & cmd_idle; // [R19]
    wire dis_set = wr_cmd & reg_wdata[`ADCC_CMD_DIS] & cmd_en & ~cmd_start; // [R17]
    wire start_set = wr_cmd & reg_wdata[`ADCC_CMD_START] & cmd_en & ~cmd_dis; // [R15]
    wire stop_set = wr_cmd & reg_wdata[`ADCC_CMD_STOP] & cmd_start & ~cmd_dis; // [R12]
    // with no conversion under way the stop finishes at once
    wire stop_done = cmd_stop & (busy ? core_stop_done : 1'b1); // [R11]
    wire down_done = (state == adcc_down) & core_off_pulse; // [R16]
    wire start_clr = stop_done
        | (trig_sw & ~cont_mode & ~disc_mode & seq_end)
        | (trig_sw & disc_mode & conv_end); // [R14]
    wire next_cmd_en = en_set | (cmd_en & ~down_done); // [R18]
    wire next_cmd_dis = dis_set | (cmd_dis & ~down_done); // [R16]
    wire next_cmd_start = start_set | (cmd_start & ~start_clr); // [R14]
    wire next_cmd_stop = stop_set | (cmd_stop & ~stop_done); // [R11]

    // ----------------------------------------------------------------
    // converter sequencing
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            adcc_off: begin
                if (cmd_en) begin
                    next_state = adcc_wake; // [R18]
                end
            end
            adcc_wake: begin
                if (cmd_dis) begin
                    next_state = adcc_down;
                end else if (core_ready_pulse) begin
                    next_state = adcc_idle;
                end
            end
            adcc_idle: begin
                if (cmd_dis) begin
                    next_state = adcc_down; // [R16]
                end else if (start_go) begin
                    next_state = adcc_busy;
                end
            end
            adcc_busy: begin
                if (stop_done | core_conv_done) begin
                    next_state = adcc_idle; // [R11]
                end
            end
            adcc_down: begin
                if (core_off_pulse) begin
                    next_state = adcc_off;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // event flags
    // ----------------------------------------------------------------
    always_comb begin
        ev_set = '0;
        ev_set[`ADCC_EV_RDY] = (state == adcc_wake) & core_ready_pulse & ~cmd_dis; // [R10]
        ev_set[`ADCC_EV_SMP] = core_sample_end & busy; // [R9]
        ev_set[`ADCC_EV_EOC] = conv_stored; // [R8]
        ev_set[`ADCC_EV_SEQ] = seq_end; // [R7]
        ev_set[`ADCC_EV_OVR] = conv_end & fif.full; // [R6]
        ev_set[`ADCC_EV_AWD] = conv_end & awd_hit; // [R3]
        ev_clr = wr_status ? reg_wdata[`ADCC_NUM_EV-1:0] : '0; // [R25]
        ev_clr[`ADCC_EV_EOC] = ev_clr[`ADCC_EV_EOC] | fifo_rd; // [R8]
        for (int i = 0; i < `ADCC_NUM_EV; i++) begin
            next_ev[i] = w1c(ev[i], ev_set[i], ev_clr[i]); // [R2]
        end
    end

    // ----------------------------------------------------------------
    // fifo hookup
    // ----------------------------------------------------------------
    assign fif.push = conv_end;
    assign fif.ovw = ovw_mode; // [R22]
    assign fif.wdata = core_data;
    assign fif.pop = fifo_rd | (dma_ack & dma_req);

    // ----------------------------------------------------------------
    // read data selection
    // ----------------------------------------------------------------
    wire [31:0] rd_status = {22'h0, fif.full, fif.empty, 2'h0, ev}; // [R4] [R5]
    wire [31:0] rd_cmd = {27'h0, cmd_stop, 1'b0, cmd_start, cmd_dis, cmd_en};
    wire [31:0] rd_fifo = {20'h0, fif.empty ? 12'h000 : fif.rdata};
    wire [31:0] rd_mux =
        (reg_addr == `ADCC_OFF_STATUS) ? rd_status :
        (reg_addr == `ADCC_OFF_IRQ_EN) ? {26'h0, ier} :
        (reg_addr == `ADCC_OFF_CMD) ? rd_cmd :
        (reg_addr == `ADCC_OFF_CFG1) ? cfg1 :
        (reg_addr == `ADCC_OFF_CFG2) ? cfg2 :
        (reg_addr == `ADCC_OFF_SMP) ? smp :
        (reg_addr == `ADCC_OFF_WDG) ? wdg :
        (reg_addr == `ADCC_OFF_THR) ? thr :
        (reg_addr == `ADCC_OFF_SEQ_LO) ? seq_lo :
        (reg_addr == `ADCC_OFF_SEQ_HI) ? seq_hi :
        (reg_addr == `ADCC_OFF_FIFO) ? rd_fifo : 32'h0000_0000; // [R21]

    // ----------------------------------------------------------------
    // state, flags and commands
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= adcc_off;
            ev <= '0;
            cmd_en <= 1'b0;
            cmd_dis <= 1'b0;
            cmd_start <= 1'b0;
            cmd_stop <= 1'b0;
        end else begin
            state <= next_state;
            ev <= next_ev;
            cmd_en <= next_cmd_en;
            cmd_dis <= next_cmd_dis;
            cmd_start <= next_cmd_start;
            cmd_stop <= next_cmd_stop;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ier <= '0;
            cfg1 <= `ADCC_RST_ZERO;
            cfg2 <= `ADCC_RST_ZERO;
            smp <= `ADCC_RST_SMP;
            wdg <= `ADCC_RST_ZERO;
            thr <= `ADCC_RST_ZERO;
            seq_lo <= `ADCC_RST_ZERO;
            seq_hi <= `ADCC_RST_ZERO;
        end else begin
            if (wr_irq_en & ~cmd_start) begin
                ier <= reg_wdata[`ADCC_NUM_EV-1:0]; // [R2]
            end
            if (cfg_wr & (reg_addr == `ADCC_OFF_CFG1)) begin
                cfg1 <= reg_wdata & `ADCC_MASK_CFG1; // [R21]
            end
            if (cfg_wr & (reg_addr == `ADCC_OFF_CFG2) & ~cmd_en) begin
                cfg2 <= reg_wdata & `ADCC_MASK_CFG2;
            end
            if (cfg_wr & (reg_addr == `ADCC_OFF_SMP)) begin
                smp <= reg_wdata & `ADCC_MASK_SMP;
            end
            if (cfg_wr & (reg_addr == `ADCC_OFF_WDG)) begin
                wdg <= reg_wdata & `ADCC_MASK_WDG;
            end
            if (cfg_wr & (reg_addr == `ADCC_OFF_THR)) begin
                thr <= reg_wdata & `ADCC_MASK_THR;
            end
            if (cfg_wr & (reg_addr == `ADCC_OFF_SEQ_LO)) begin
                seq_lo <= reg_wdata & `ADCC_MASK_SEQ;
            end
            if (cfg_wr & (reg_addr == `ADCC_OFF_SEQ_HI)) begin
                seq_hi <= reg_wdata & `ADCC_MASK_SEQ;
            end
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
            reg_ack <= 1'b0;
            core_power_on <= 1'b0;
            core_start_conv <= 1'b0;
            core_abort <= 1'b0;
            core_differential_select_sel <= 1'b0;
            core_temp_sel <= 1'b0;
            dma_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            reg_rdata <= acc_rd ? rd_mux : 32'h0000_0000;
            reg_ack <= reg_sel;
            core_power_on <= (next_state != adcc_off) & (next_state != adcc_down); // [R18]
            core_start_conv <= start_go; // [R13]
            core_abort <= next_cmd_stop; // [R11]
            core_differential_select_sel <= cfg1[`ADCC_CFG_DIFFERENTIAL_SELECT]; // [R20]
            core_temp_sel <= (core_channel == `ADCC_TEMP_CH) & (next_state == adcc_busy); // [R1]
            dma_req <= dma_en & ~next_ev[`ADCC_EV_OVR] & (~fif.empty | fif.push); // [R23]
            irq <= |(next_ev & ier); // [R25]
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_overrun_on_full: assert property ( // [R6]
        conv_end & fif.full |=> ev[`ADCC_EV_OVR]) else $error("overrun flag missed");
    a_empty_status: assert property ( // [R4]
        acc_rd & (reg_addr == `ADCC_OFF_STATUS) |=> reg_rdata[`ADCC_ST_EMPTY] == $past(fif.empty))
        else $error("empty status wrong");
    a_full_status: assert property ( // [R5]
        acc_rd & (reg_addr == `ADCC_OFF_STATUS) |=> reg_rdata[`ADCC_ST_FULL] == $past(fif.full))
        else $error("full status wrong");
    a_seq_done_set: assert property ( // [R7]
        seq_end |=> ev[`ADCC_EV_SEQ] & (state == adcc_idle)) else $error("sequence flag missed");
    a_read_clears_eoc: assert property ( // [R8]
        fifo_rd & ~conv_stored |=> ~ev[`ADCC_EV_EOC]) else $error("fifo read kept flag");
    a_stop_clears_both: assert property ( // [R11]
        cmd_stop & busy & core_stop_done |=> ~cmd_stop & ~cmd_start & ~core_abort)
        else $error("stop not completed");
    a_disable_done: assert property ( // [R16]
        down_done |=> ~cmd_en & ~cmd_dis ##1 ~core_power_on) else $error("disable left bits");
    a_ready_sets: assert property ( // [R10]
        (state == adcc_wake) & core_ready_pulse & ~cmd_dis |=> ev[`ADCC_EV_RDY] ##1 core_power_on)
        else $error("ready flag missed");
    a_sw_start_now: assert property ( // [R13]
        (state == adcc_idle) & cmd_start & trig_sw & ~cmd_stop & ~cmd_dis & ~wait_block
        |=> core_start_conv ##1 ~core_start_conv) else $error("start not issued");
    a_wait_holds_start: assert property ( // [R24]
        (state == adcc_idle) & wait_block |=> ~core_start_conv) else $error("start while full");
    a_dma_blocked: assert property ( // [R23]
        ev[`ADCC_EV_OVR] |-> ~dma_req) else $error("dma request after overrun");
    a_zero_keeps_flag: assert property ( // [R25]
        ev[`ADCC_EV_AWD] & wr_status & ~reg_wdata[`ADCC_EV_AWD] |=> ev[`ADCC_EV_AWD])
        else $error("zero write cleared flag");
    a_irq_follows: assert property ( // [R2]
        |(ev & ier) & $stable(ev & ier) |-> irq) else $error("irq not raised");
    a_disc_start_clr: assert property ( // [R14]
        trig_sw & disc_mode & conv_end & ~start_set |=> ~cmd_start) else $error("start not cleared");

    c_full_sequence: cover property (start_go ##[1:200] seq_end);
    c_overrun: cover property (conv_end & fif.full);
    c_stop_abort: cover property (cmd_stop & busy ##[1:50] core_stop_done);
    c_power_cycle: cover property ((state == adcc_idle) ##[1:100] down_done);
endmodule
`default_nettype wire

// *** core/adcc_fifo.sv ***
`default_nettype none
module adcc_fifo #(
    parameter int W = 12,
    parameter int D = 8
) (
    input wire logic clk_sys,
    input wire logic rstn,
    adcc_fifo_if.store fif
);
    localparam int AW = $clog2(D);
    if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
        $error("fifo depth must be a power of two, at least 2");
    end
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    wire do_pop = fif.pop & ~fif.empty;
    wire do_push = fif.push & (~fif.full | do_pop);
    // overwrite mode: newest slot takes the fresh result
    wire do_ovw = fif.push & fif.full & ~do_pop & fif.ovw;
    assign fif.empty = (cnt == '0);
    assign fif.full = (cnt == (AW+1)'(D));
    assign fif.rdata = mem[rp];
    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem[wp] <= fif.wdata;
        end else if (do_ovw) begin
            mem[wp - 1'b1] <= fif.wdata;
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= wp + AW'(do_push);
            rp <= rp + AW'(do_pop);
            cnt <= cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule
`default_nettype wire

// *** core/adcc_fifo_if.sv ***
`default_nettype none
interface adcc_fifo_if #(parameter int W = 12);
    logic push;
    logic ovw;
    logic [W-1:0] wdata;
    logic pop;
    logic [W-1:0] rdata;
    logic empty;
    logic full;
    modport ctrl(output push, ovw, wdata, pop, input rdata, empty, full);
    modport store(input push, ovw, wdata, pop, output rdata, empty, full);
endinterface
`default_nettype wire

// *** core/adcc_map.svh ***
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADCC_OFF_STATUS 7'h00
`define ADCC_OFF_IRQ_EN 7'h04
`define ADCC_OFF_CMD 7'h08
`define ADCC_OFF_CFG1 7'h0c
`define ADCC_OFF_CFG2 7'h10
`define ADCC_OFF_SMP 7'h14
`define ADCC_OFF_WDG 7'h18
`define ADCC_OFF_THR 7'h1c
`define ADCC_OFF_SEQ_LO 7'h2c
`define ADCC_OFF_SEQ_HI 7'h30
`define ADCC_OFF_FIFO 7'h4c
// ----------------------------------------------------------------
// event flag / enable positions and status bits
// ----------------------------------------------------------------
`define ADCC_EV_RDY 0
`define ADCC_EV_SMP 1
`define ADCC_EV_EOC 2
`define ADCC_EV_SEQ 3
`define ADCC_EV_OVR 4
`define ADCC_EV_AWD 5
`define ADCC_NUM_EV 6
`define ADCC_ST_EMPTY 8
`define ADCC_ST_FULL 9
// ----------------------------------------------------------------
// command bits
// ----------------------------------------------------------------
`define ADCC_CMD_EN 0
`define ADCC_CMD_DIS 1
`define ADCC_CMD_START 2
`define ADCC_CMD_STOP 4
// ----------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------
`define ADCC_CFG_DMA 0
`define ADCC_CFG_TRIG_HI 3
`define ADCC_CFG_TRIG_LO 1
`define ADCC_CFG_OVW 4
`define ADCC_CFG_WAIT 5
`define ADCC_CFG_CONT 6
`define ADCC_CFG_DISC 7
`define ADCC_CFG_DIFFERENTIAL_SELECT 8
`define ADCC_WDG_CH_HI 3
`define ADCC_WDG_CH_LO 0
`define ADCC_WDG_SGL 6
`define ADCC_WDG_EN 7
`define ADCC_THR_LT_HI 11
`define ADCC_THR_LT_LO 0
`define ADCC_THR_HT_HI 27
`define ADCC_THR_HT_LO 16
`define ADCC_TEMP_CH 4'hf
`define ADCC_TRIG_SW 3'h0
// ----------------------------------------------------------------
// write masks and reset values
// ----------------------------------------------------------------
`define ADCC_MASK_CFG1 32'h0000_01ff
`define ADCC_MASK_CFG2 32'h0000_ff0f
`define ADCC_MASK_SMP 32'h0000_00ff
`define ADCC_MASK_WDG 32'h0000_00cf
`define ADCC_MASK_THR 32'h0fff_0fff
`define ADCC_MASK_SEQ 32'hffff_ffff
`define ADCC_RST_SMP 32'h0000_0002
`define ADCC_RST_ZERO 32'h0000_0000
`endif

// *** core/adcc_pkg.sv ***
`default_nettype none
package adcc_pkg;
    typedef enum logic [2:0] {
        adcc_off,
        adcc_wake,
        adcc_idle,
        adcc_busy,
        adcc_down
    } adcc_state_t;
    typedef logic [11:0] adcc_sample_t;
endpackage
`default_nettype wire

// *** testbench/adc_control_status_logic_tb.sv ***
`default_nettype none
module adc_control_status_logic_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic w; logic [6:0] a; logic [31:0] d; logic [31:0] e;} adcc_row_t;
    localparam adcc_row_t ROWS[13] = '{'{0, 7'h14, 0, 32'h2}, '{0, 7'h00, 0, 32'h100},
        '{1, 7'h18, 32'h80, 0}, '{0, 7'h18, 0, 32'h80},
        '{1, 7'h0c, 32'hffffffff, 0}, '{0, 7'h0c, 0, 32'h1ff}, '{1, 7'h0c, 32'h101, 0},
        '{1, 7'h20, 32'hff, 0}, '{0, 7'h20, 0, 0}, '{1, 7'h08, 32'h4, 0},
        '{0, 7'h08, 0, 0}, '{1, 7'h04, 32'h3f, 0}, '{0, 7'h04, 0, 32'h3f}};
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic reg_sel = 1'b0;
    logic reg_wr = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, q;
    logic reg_ack, rdy, off, sdone, smp, cdone, last, pwr, sconv, abrt, differential_select, tsel, dreq, irq;
    adcc_pkg::adcc_sample_t cdata;
    logic [3:0] chan;
    logic trig = 1'b0;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    always #25 clk_sys = ~clk_sys;
    adcc_ctrl #(.FIFO_DEPTH(2)) i_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_sel(reg_sel),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .core_ready_pulse(rdy), .core_off_pulse(off),
        .core_stop_done(sdone), .core_sample_end(smp), .core_conv_done(cdone),
        .core_seq_last(last), .core_data(cdata), .core_channel(chan), .hw_trigger(trig),
        .dma_ack(1'b0), .core_power_on(pwr), .core_start_conv(sconv), .core_abort(abrt),
        .core_differential_select_sel(differential_select), .core_temp_sel(tsel), .dma_req(dreq), .irq(irq));
    adcc_core_model i_core (.clk_sys(clk_sys), .rstn(rstn), .core_power_on(pwr),
        .core_start_conv(sconv), .core_abort(abrt), .core_ready_pulse(rdy),
        .core_off_pulse(off), .core_stop_done(sdone), .core_sample_end(smp),
        .core_conv_done(cdone), .core_seq_last(last), .core_data(cdata), .core_channel(chan));
    // ----------------------------------------------------------------
    // bus access and comparison
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic acc(input logic w, input logic [6:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_sel <= 1'b1;
        reg_wr <= w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_sel <= 1'b0;
        #1 q = reg_rdata;
        chk({31'h0, reg_ack}, 32'h1);
    endtask
    task automatic poll(input logic [6:0] a, input logic [31:0] m, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        for (int i = 0; i < 40 && (q & m) !== e; i++) begin
            acc(1'b0, a, 32'h0);
        end
        chk(q & m, e);
    endtask
    task automatic wrap_up;
        if (error_cnt == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        foreach (ROWS[i]) begin
            acc(ROWS[i].w, ROWS[i].a, ROWS[i].d);
            if (!ROWS[i].w) chk(q, ROWS[i].e);
        end
        chk({31'h0, differential_select}, 32'h1);
        acc(1'b1, 7'h08, 32'h1);
        poll(7'h00, 32'h1, 32'h1);
        chk({31'h0, irq}, 32'h1);
        acc(1'b1, 7'h00, 32'h0);
        poll(7'h00, 32'h1, 32'h1);
        acc(1'b1, 7'h00, 32'h3f);
        poll(7'h00, 32'h3f, 32'h0);
        chk({31'h0, irq}, 32'h0);
        for (int n = 0; n < 3; n++) begin
            acc(1'b1, 7'h08, 32'h4);
            @(posedge clk_sys) #1 chk({31'h0, sconv}, 32'h1);
            @(posedge clk_sys) #1 chk({31'h0, tsel}, {31'h0, !n[0]});
            poll(7'h08, 32'h4, 32'h0);
            if (n == 0) begin
                poll(7'h00, 32'h33e, 32'h02e);
                chk({31'h0, dreq}, 32'h1);
            end
        end
        poll(7'h00, 32'h310, 32'h210);
        chk({31'h0, dreq}, 32'h0);
        acc(1'b1, 7'h00, 32'h10);
        poll(7'h00, 32'h30, 32'h20);
        chk({31'h0, dreq}, 32'h1);
        acc(1'b0, 7'h4c, 32'h0);
        chk(q, 32'h0a1);
        acc(1'b0, 7'h4c, 32'h0);
        chk(q, 32'h0a2);
        poll(7'h00, 32'h304, 32'h100);
        acc(1'b1, 7'h0c, 32'h103);
        acc(1'b1, 7'h08, 32'h4);
        acc(1'b0, 7'h08, 32'h0);
        chk(q, 32'h5);
        @(posedge clk_sys) trig <= 1'b1;
        @(posedge clk_sys) trig <= 1'b0;
        #1 chk({31'h0, sconv}, 32'h1);
        acc(1'b1, 7'h08, 32'h10);
        chk({31'h0, abrt}, 32'h1);
        poll(7'h08, 32'h14, 32'h0);
        acc(1'b1, 7'h08, 32'h2);
        poll(7'h08, 32'h3, 32'h0);
        chk({31'h0, pwr}, 32'h0);
        @(posedge clk_sys) rstn <= 1'b0;
        @(posedge clk_sys) rstn <= 1'b1;
        acc(1'b0, 7'h04, 32'h0);
        chk(q, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire

// *** testbench/adcc_core_model.sv ***
`default_nettype none
// ----------------------------------------------------------------
// analog core stand-in: power-up, sampling, conversion, abort
// ----------------------------------------------------------------
module adcc_core_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic core_power_on,
    input wire logic core_start_conv,
    input wire logic core_abort,
    output logic core_ready_pulse,
    output logic core_off_pulse,
    output logic core_stop_done,
    output logic core_sample_end,
    output logic core_conv_done,
    output logic core_seq_last,
    output adcc_pkg::adcc_sample_t core_data,
    output logic [3:0] core_channel
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pwr_d;
    logic [3:0] wake;
    logic [5:0] conv;
    adcc_pkg::adcc_sample_t cnt;
    assign core_ready_pulse = wake[3];
    assign core_sample_end = conv[2];
    assign core_conv_done = conv[5];
    assign core_seq_last = conv[5];
    // odd results come from the temperature channel, even ones from channel 0
    assign core_channel = {4{cnt[0]}};
    // data only valid with the done pulse, scrambled otherwise
    assign core_data = conv[5] ? cnt : ~cnt;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pwr_d <= 1'b0;
            wake <= 4'h0;
            conv <= 6'h00;
            cnt <= 12'h0a1;
            core_off_pulse <= 1'b0;
            core_stop_done <= 1'b0;
        end else begin
            pwr_d <= core_power_on;
            wake <= {wake[2:0], core_power_on & ~pwr_d};
            core_off_pulse <= pwr_d & ~core_power_on;
            conv <= core_abort ? 6'h00 : {conv[4:0], core_start_conv};
            core_stop_done <= core_abort & ~core_stop_done;
            if (conv[5]) begin
                cnt <= cnt + 12'h001;
            end
        end
    end
endmodule
`default_nettype wire
